// *** timer_channel_start_stop.sv ***
// start/stop triggers, enable status and counter initialisation for eight timer channels
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "tmr_start_stop_params.svh"

// Overview of operation
// - status bits 7..0 read 1 while a channel counts, 0 when stopped.
// - status bits 9 and 11 show upper half enable of channels 1 and 3.
// - writing 1 to a start bit sets that channel's status bit.
// - writing 1 to a stop bit clears that channel's status bit.
// - start register bits 7..0 start channels; zero bits do nothing.
// - start bits 9 and 11 start upper halves of channels 1 and 3 while that channel is split.
// - stop register bits 7..0 stop channels; zero bits do nothing.
// - stop bits 9 and 11 stop upper halves of channels 1 and 3.
// - start register always reads zero.
// - stop register always reads zero.
// - start triggers clear themselves once the status is set.
// - stop triggers clear themselves once the status is cleared.
// - a start also reinitialises the channel counter.
// - in split mode the channel start bit starts only the lower byte timer.
// - upper byte timers count as interval timers once started.
// - status low byte is readable by a single byte access.
// - bits 8, 10 and 15..12 read zero; software writes zero there.
// - after reset all status and trigger bits are zero.
// - per-channel split bit selects 8-bit halves for channels 1 and 3 only.
module timer_channel_start_stop #(
	parameter int NUM_CHAN = 8,
	parameter int CNT_W = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [15:0] channel_enable_status,
	output logic [NUM_CHAN-1:0] counter_init_pulse,
	output logic [NUM_CHAN-1:0][CNT_W-1:0] channel_counter
);

	//------------------------------------------------------------
	// address map
	//------------------------------------------------------------
	localparam logic [13:0] ADDR_STATUS = {`IDX_CHANNEL_ENABLE_STATUS, 2'b00};
	localparam logic [13:0] ADDR_START = {`IDX_CHANNEL_START_TRIGGER, 2'b00};
	localparam logic [13:0] ADDR_STOP = {`IDX_CHANNEL_STOP_TRIGGER, 2'b00};
	localparam logic [13:0] ADDR_MODE = {`IDX_CHANNEL_MODE_CONFIG, 2'b00};
	localparam logic [15:0] VALID_BITS = 16'h0AFF;

	//------------------------------------------------------------
	// state
	//------------------------------------------------------------
	tmr_start_stop_pkg::ahb_addr_phase_t aph_ff, nxt_aph;
	tmr_start_stop_pkg::chan_trig_t start_trig_ff, nxt_start_trig;
	tmr_start_stop_pkg::chan_trig_t stop_trig_ff, nxt_stop_trig;
	logic [15:0] status_ff, nxt_status;
	logic [7:0] mode_ff, nxt_mode;
	logic [31:0] hrdata_ff, nxt_hrdata;
	logic [NUM_CHAN-1:0] init_ff, nxt_init;
	logic [NUM_CHAN-1:0][CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [15:0] wmask;
	logic [15:0] wval;

	//------------------------------------------------------------
	// bus slave
	//------------------------------------------------------------
	// byte lanes of the lower halfword; upper lanes hold no bits
	always_comb begin
		wmask = 16'h0000;
		if (aph_ff.size == `HSIZE_BYTE) begin
			if (aph_ff.addr[1:0] == 2'h0) begin
				wmask = 16'h00FF;
			end else if (aph_ff.addr[1:0] == 2'h1) begin
				wmask = 16'hFF00;
			end
		end else begin
			wmask = 16'hFFFF;
		end
		wval = hwdata[15:0] & wmask & VALID_BITS;
	end

	always_comb begin
		nxt_aph = aph_ff;
		nxt_hrdata = hrdata_ff;
		if (hready) begin
			nxt_aph.valid = hsel && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
			nxt_aph.write = hwrite;
			nxt_aph.size = hsize;
			nxt_aph.addr = haddr[13:0];
			nxt_hrdata = 32'h0000_0000;
			// trigger registers read zero; unmapped addresses read zero too
			if (hsel && !hwrite && htrans[1]) begin
				case ({haddr[13:2], 2'b00})
					ADDR_STATUS: nxt_hrdata = {16'h0000, nxt_status & VALID_BITS};
					ADDR_START: nxt_hrdata = 32'h0000_0000;
					ADDR_STOP: nxt_hrdata = 32'h0000_0000;
					ADDR_MODE: nxt_hrdata = {24'h00_0000, mode_ff};
					default: nxt_hrdata = 32'h0000_0000;
				endcase
			end
		end
	end

	//------------------------------------------------------------
	// triggers, status and mode
	//------------------------------------------------------------
	always_comb begin
		logic wr;
		wr = aph_ff.valid && aph_ff.write;
		// triggers live one cycle: they clear as the status takes them
		nxt_start_trig = '0;
		nxt_stop_trig = '0;
		nxt_mode = mode_ff;
		if (wr && {aph_ff.addr[13:2], 2'b00} == ADDR_START) begin
			nxt_start_trig.chan = wval[`FLD_CHAN_HI:`FLD_CHAN_LO];
			nxt_start_trig.upper1 = wval[`FLD_UPPER_CH1];
			nxt_start_trig.upper3 = wval[`FLD_UPPER_CH3];
		end
		if (wr && {aph_ff.addr[13:2], 2'b00} == ADDR_STOP) begin
			nxt_stop_trig.chan = wval[`FLD_CHAN_HI:`FLD_CHAN_LO];
			nxt_stop_trig.upper1 = wval[`FLD_UPPER_CH1];
			nxt_stop_trig.upper3 = wval[`FLD_UPPER_CH3];
		end
		if (wr && {aph_ff.addr[13:2], 2'b00} == ADDR_MODE && wmask[0]) begin
			// only channels 1 and 3 own a split bit
			nxt_mode = 8'h00;
			nxt_mode[`FLD_SPLIT_CH1] = hwdata[`FLD_SPLIT_CH1];
			nxt_mode[`FLD_SPLIT_CH3] = hwdata[`FLD_SPLIT_CH3];
		end

		nxt_status = status_ff;
		nxt_status[`FLD_CHAN_HI:`FLD_CHAN_LO] = (status_ff[`FLD_CHAN_HI:`FLD_CHAN_LO]
			| start_trig_ff.chan) & ~stop_trig_ff.chan;
		// an upper half only starts while its channel is split
		nxt_status[`FLD_UPPER_CH1] = (status_ff[`FLD_UPPER_CH1]
			| (start_trig_ff.upper1 & mode_ff[`FLD_SPLIT_CH1])) & ~stop_trig_ff.upper1;
		nxt_status[`FLD_UPPER_CH3] = (status_ff[`FLD_UPPER_CH3]
			| (start_trig_ff.upper3 & mode_ff[`FLD_SPLIT_CH3])) & ~stop_trig_ff.upper3;
		nxt_status = nxt_status & VALID_BITS;
	end

	//------------------------------------------------------------
	// channel counters
	//------------------------------------------------------------
	// counters start from zero and count up every clock while enabled;
	// mode-specific counting is outside this block
	always_comb begin
		logic split;
		logic upper_start;
		logic upper_run;
		nxt_cnt = cnt_ff;
		nxt_init = '0;
		split = 1'b0;
		upper_start = 1'b0;
		upper_run = 1'b0;
		for (int i = 0; i < NUM_CHAN; i++) begin
			split = (i == `FLD_SPLIT_CH1 && mode_ff[`FLD_SPLIT_CH1])
				|| (i == `FLD_SPLIT_CH3 && mode_ff[`FLD_SPLIT_CH3]);
			upper_start = (i == 1) ? start_trig_ff.upper1 : start_trig_ff.upper3;
			upper_run = (i == 1) ? status_ff[`FLD_UPPER_CH1] : status_ff[`FLD_UPPER_CH3];
			nxt_init[i] = start_trig_ff.chan[i] & ~stop_trig_ff.chan[i];
			if (split) begin
				// halves are independent 8-bit timers
				if (start_trig_ff.chan[i]) begin
					nxt_cnt[i][7:0] = 8'h00;
				end else if (status_ff[i]) begin
					nxt_cnt[i][7:0] = cnt_ff[i][7:0] + 8'h01;
				end
				if (upper_start) begin
					nxt_cnt[i][15:8] = 8'h00;
				end else if (upper_run) begin
					nxt_cnt[i][15:8] = cnt_ff[i][15:8] + 8'h01;
				end
			end else if (start_trig_ff.chan[i]) begin
				nxt_cnt[i] = '0;
			end else if (status_ff[i]) begin
				nxt_cnt[i] = cnt_ff[i] + CNT_W'(1);
			end
		end
	end

	//------------------------------------------------------------
	// registers
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aph_ff <= '0;
			hrdata_ff <= 32'h0000_0000;
			start_trig_ff <= 10'(`RST_TRIGGER);
			stop_trig_ff <= 10'(`RST_TRIGGER);
			status_ff <= `RST_STATUS;
			mode_ff <= `RST_MODE;
			init_ff <= '0;
			cnt_ff <= '0;
		end else begin
			aph_ff <= nxt_aph;
			hrdata_ff <= nxt_hrdata;
			start_trig_ff <= nxt_start_trig;
			stop_trig_ff <= nxt_stop_trig;
			status_ff <= nxt_status;
			mode_ff <= nxt_mode;
			init_ff <= nxt_init;
			cnt_ff <= nxt_cnt;
		end
	end

	// zero-wait slave: ready is a flop held high after reset; response is tied to okay
	logic hreadyout_ff;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_ff <= 1'b0;
		end else begin
			hreadyout_ff <= 1'b1;
		end
	end

	assign hreadyout = hreadyout_ff;
	assign hresp = 1'b0 & hreadyout_ff;
	assign hrdata = hrdata_ff;
	assign channel_enable_status = status_ff;
	assign counter_init_pulse = init_ff;
	assign channel_counter = cnt_ff;

endmodule : timer_channel_start_stop

// *** timer_channel_start_stop_tb.sv ***
// self-checking bench for the channel start/stop block
`timescale 1ns/1ps
`include "tmr_start_stop_params.svh"
module timer_channel_start_stop_tb;
	localparam logic [31:0] A_STAT = `IDX_CHANNEL_ENABLE_STATUS * 4;
	localparam logic [31:0] A_STRT = `IDX_CHANNEL_START_TRIGGER * 4;
	localparam logic [31:0] A_STOP = `IDX_CHANNEL_STOP_TRIGGER * 4;
	localparam logic [31:0] A_MODE = `IDX_CHANNEL_MODE_CONFIG * 4;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	wire logic hreadyout;
	wire logic hresp;
	wire logic [31:0] hrdata;
	wire logic [15:0] channel_enable_status;
	wire logic [7:0] counter_init_pulse;
	wire logic [7:0][15:0] channel_counter;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	timer_channel_start_stop timer_channel_start_stop_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .channel_enable_status(channel_enable_status),
		.counter_init_pulse(counter_init_pulse), .channel_counter(channel_counter));
	always #20 hclk = ~hclk;
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic xfer(input logic w, input logic [31:0] a, input logic [2:0] s, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= `HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= s;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : xfer
	task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp32
	// two idle edges let a trigger land in the status before the next read
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, 3'h2, d, r);
		repeat (2) @(posedge hclk);
	endtask : wr
	task automatic rd_chk(input logic [31:0] a, input logic [2:0] s, input logic [31:0] exp);
		logic [31:0] r;
		xfer(1'b0, a, s, 32'h0, r);
		cmp32("hrdata", exp, (s == `HSIZE_BYTE) ? (r & 32'hFF) : r);
	endtask : rd_chk
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd_chk(A_STAT, 3'h2, 32'h0);
		rd_chk(A_STRT, 3'h2, 32'h0);
		rd_chk(A_STOP, 3'h2, 32'h0);
		rd_chk(32'h600, 3'h2, 32'h0);
	endtask : t_reset
	task automatic t_start();
		for (int n = 0; n < 8; n++) begin
			wr(A_STRT, 32'h1 << n);
			rd_chk(A_STAT, 3'h2, (32'h2 << n) - 32'h1);
		end
		rd_chk(A_STRT, 3'h2, 32'h0);
	endtask : t_start
	task automatic t_stop();
		wr(A_STOP, 32'h55);
		rd_chk(A_STAT, 3'h2, 32'hAA);
		wr(A_STOP, 32'h0);
		wr(A_STRT, 32'h0);
		rd_chk(A_STAT, 3'h2, 32'hAA);
		rd_chk(A_STOP, 3'h2, 32'h0);
		wr(A_STOP, 32'hFF);
	endtask : t_stop
	task automatic t_split();
		wr(A_STRT, 32'h0A00);
		rd_chk(A_STAT, 3'h2, 32'h0);
		wr(A_MODE, 32'h0A);
		repeat (4) @(posedge hclk);
		wr(A_STRT, 32'h0A00);
		rd_chk(A_STAT, 3'h2, 32'h0A00);
		wr(A_STRT, 32'h02);
		rd_chk(A_STAT, 3'h2, 32'h0A02);
		wr(A_STOP, 32'h0200);
		rd_chk(A_STAT, 3'h2, 32'h0802);
		rd_chk(A_STAT, `HSIZE_BYTE, 32'h02);
		wr(A_STOP, 32'h0800);
		rd_chk(A_STAT, 3'h2, 32'h02);
	endtask : t_split
	// outputs are read just at the edge, before that edge updates them
	task automatic t_count();
		logic [31:0] r;
		logic [15:0] v;
		xfer(1'b1, A_STRT, 3'h2, 32'h4, r);
		repeat (2) @(posedge hclk);
		cmp32("counter_init_pulse", 32'h4, {24'h0, counter_init_pulse});
		cmp32("channel_counter", 32'h0, {16'h0, channel_counter[2]});
		repeat (6) @(posedge hclk);
		cmp32("counter_init_pulse", 32'h0, {24'h0, counter_init_pulse});
		cmp32("channel_counter", 32'h6, {16'h0, channel_counter[2]});
		xfer(1'b1, A_STOP, 3'h2, 32'h4, r);
		repeat (2) @(posedge hclk);
		v = channel_counter[2];
		repeat (3) @(posedge hclk);
		cmp32("channel_enable_status", 32'h0, {31'h0, channel_enable_status[2]});
		cmp32("channel_counter", {16'h0, v}, {16'h0, channel_counter[2]});
	endtask : t_count
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			print_verdict();
		end
	end
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		t_reset();
		t_start();
		t_stop();
		t_split();
		t_count();
		print_verdict();
	end
endmodule : timer_channel_start_stop_tb

// *** tmr_start_stop_asserts.sv ***
// port-level checks of the channel start/stop block
`timescale 1ns/1ps
`include "tmr_start_stop_params.svh"
module tmr_start_stop_asserts #(
	parameter int NUM_CHAN = 8,
	parameter int CNT_W = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [15:0] channel_enable_status,
	input wire logic [NUM_CHAN-1:0] counter_init_pulse,
	input wire logic [NUM_CHAN-1:0][CNT_W-1:0] channel_counter
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ----------------------------------------
	// bus response, trigger reads, status and counter relations
	// ----------------------------------------
	sequence addr_ok_s;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence trig_rd_s;
		addr_ok_s ##0 (haddr == `IDX_CHANNEL_START_TRIGGER * 4 || haddr == `IDX_CHANNEL_STOP_TRIGGER * 4);
	endsequence
	chk_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
	chk_ready_held: assert property ($past(hresetn) |-> hreadyout) else $error("hreadyout dropped");
	chk_trig_zero: assert property (trig_rd_s |=> hrdata == 32'h0) else $error("trigger read not zero");
	chk_reserved_zero: assert property (channel_enable_status[8] == 1'b0 && channel_enable_status[10] == 1'b0
		&& channel_enable_status[15:12] == 4'h0) else $error("reserved status bit set");
	chk_rise_pulse: assert property (((channel_enable_status[7:0] & ~$past(channel_enable_status[7:0]))
		& ~counter_init_pulse) == 8'h00) else $error("status rose without init pulse");
	chk_pulse_status: assert property ((counter_init_pulse & ~channel_enable_status[7:0]) == 8'h00)
		else $error("init pulse on disabled channel");
	chk_init_clear: assert property (counter_init_pulse[0] |-> channel_counter[0] == 16'h0000)
		else $error("counter not initialised");
	chk_count_up: assert property (channel_enable_status[0] && $past(channel_enable_status[0]) && !counter_init_pulse[0]
		|-> channel_counter[0] - $past(channel_counter[0]) == 16'h0001) else $error("counter not counting");
	chk_stop_hold: assert property (!channel_enable_status[0] && !$past(channel_enable_status[0])
		|-> $stable(channel_counter[0])) else $error("stopped counter moved");
endmodule : tmr_start_stop_asserts
bind timer_channel_start_stop tmr_start_stop_asserts #(.NUM_CHAN(NUM_CHAN), .CNT_W(CNT_W)) tmr_start_stop_asserts_i (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .channel_enable_status(channel_enable_status),
	.counter_init_pulse(counter_init_pulse), .channel_counter(channel_counter));

// *** tmr_start_stop_params.svh ***
// register offsets, field positions and reset values of the channel start/stop block
`ifndef TMR_START_STOP_PARAMS_SVH
`define TMR_START_STOP_PARAMS_SVH

// printed offsets are register indices; byte address is four times the index
`define IDX_CHANNEL_ENABLE_STATUS 12'h130
`define IDX_CHANNEL_START_TRIGGER 12'h132
`define IDX_CHANNEL_STOP_TRIGGER 12'h134
`define IDX_CHANNEL_MODE_CONFIG 12'h140

`define FLD_CHAN_LO 0
`define FLD_CHAN_HI 7
`define FLD_UPPER_CH1 9
`define FLD_UPPER_CH3 11
`define FLD_SPLIT_CH1 1
`define FLD_SPLIT_CH3 3

`define RST_STATUS 16'h0000
`define RST_TRIGGER 16'h0000
`define RST_MODE 8'h00
`define RST_COUNTER 16'h0000

`define HSIZE_BYTE 3'h0
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3

`endif

// *** tmr_start_stop_pkg.sv ***
// types shared by the channel start/stop block
package tmr_start_stop_pkg;

	// latched address phase of an ahb-lite transfer
	typedef struct packed {
		logic valid;
		logic write;
		logic [2:0] size;
		logic [13:0] addr;
	} ahb_addr_phase_t;

	// trigger bits: eight channels plus the two upper halves
	typedef struct packed {
		logic upper3;
		logic upper1;
		logic [7:0] chan;
	} chan_trig_t;

endpackage : tmr_start_stop_pkg
